// >>> verilog/pwm_timebase_pkg.sv
// constants shared by the primary time base control block and its helpers
package pwm_timebase_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CTRL_W = 16;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_PERIOD = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_SEVT_CMP = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h18;

  // control register field positions
  localparam int unsigned BIT_MODULE_ON = 15;
  localparam int unsigned BIT_UNUSED = 14;
  localparam int unsigned BIT_IDLE_HALT = 13;
  localparam int unsigned BIT_SE_PENDING = 12;
  localparam int unsigned BIT_SE_IRQ_EN = 11;
  localparam int unsigned BIT_IMM_LOAD = 10;
  localparam int unsigned BIT_SYNC_POL = 9;
  localparam int unsigned BIT_SYNC_OE = 8;
  localparam int unsigned BIT_EXT_SYNC = 7;
  localparam int unsigned SRC_LSB = 4;
  localparam int unsigned SRC_W = 3;
  localparam int unsigned PS_LSB = 0;
  localparam int unsigned PS_W = 4;

  // bits that software may write in the control register
  localparam logic [15:0] CONTROL_WMASK = 16'hafff;

  // values after reset
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic [15:0] SEVT_CMP_RST = 16'h0000;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // interrupt status layout
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_BOUNDARY = 0;
  localparam int unsigned IRQ_SPECIAL = 1;
  localparam int unsigned IRQ_SYNC = 2;

endpackage : pwm_timebase_pkg

// >>> verilog/sync_source_edge.sv
// selects one sync input, applies polarity and flags its asserting edge
`timescale 1ns/10ps
module sync_source_edge
  import pwm_timebase_pkg::*;
#(
  parameter int unsigned SRC_N = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [SRC_N-1:0] sync_sources,
  input wire logic [SRC_W-1:0] select,
  input wire logic invert,
  output logic sync_pulse
);

  // registered state of the edge detector
  typedef struct packed {
    logic level;  // asserted level seen last cycle
    logic pulse;  // one-cycle edge flag
  } edge_state_s;

  edge_state_s s;
  edge_state_s n;
  logic active;  // selected source at its active level

  // next state: detect a fresh assertion of the selected source
  always_comb begin
    n = s;
    active = 1'b0;
    if (32'(select) < SRC_N) begin
      active = sync_sources[select] ^ invert;
    end
    n.level = active;
    n.pulse = active & ~s.level;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign sync_pulse = s.pulse;

endmodule : sync_source_edge

// >>> verilog/event_postscaler.sv
// passes one of every (ratio + 1) input events
`timescale 1ns/10ps
module event_postscaler
  import pwm_timebase_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic event_in,
  input wire logic [PS_W-1:0] ratio,
  output logic event_out
);

  // registered state of the divider
  typedef struct packed {
    logic [PS_W-1:0] count;  // events seen since last output
    logic out;               // one-cycle output flag
  } ps_state_s;

  ps_state_s s;
  ps_state_s n;

  // next state: count events, emit on the selected one
  always_comb begin
    n = s;
    n.out = 1'b0;
    if (clear) begin
      // disabled module restarts the division
      n.count = '0;
    end else if (event_in) begin
      if (s.count >= ratio) begin
        n.count = '0;
        n.out = 1'b1;
      end else begin
        n.count = s.count + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign event_out = s.out;

endmodule : event_postscaler

// >>> verilog/pwm_timebase_control.sv
// primary pwm time base with its control register, apb slave and interrupt
`timescale 1ns/10ps
module pwm_timebase_control
  import pwm_timebase_pkg::*;
#(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned SRC_N = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_idle,
  input wire logic [SRC_N-1:0] sync_sources,
  output logic sync_output_pin,
  output logic sync_output_en,
  output logic pwm_running,
  output logic period_boundary,
  output logic [CNT_W-1:0] count_value,
  output logic [CNT_W-1:0] active_period,
  output logic irq
);

  // register map, one aligned word per register, 16-bit values in the low bits
  //   control - enable, idle halt, pending view, mode bits, source, postscale
  //   period  - period written by software, copied to the active period
  //   count   - live time base count, read only
  //   compare - count value that raises a special event
  //   status  - sticky boundary, special event and external sync bits
  //   enable  - per-bit interrupt enables, same layout as status
  //   clear   - write ones to drop status bits, reads zero
  // offsets are byte addresses, all multiples of four
  // upper bus bits read zero and are ignored on writes
  // an address outside the map answers with an error and changes nothing

  // all registered state of the block
  typedef struct packed {
    logic [CTRL_W-1:0] control;    // software control bits
    logic [CNT_W-1:0] period;      // period written by software
    logic [CNT_W-1:0] active;      // period the counter compares against
    logic [CNT_W-1:0] count;       // time base count
    logic [CNT_W-1:0] sevt_cmp;    // special event compare value
    logic [IRQ_W-1:0] irq_status;  // sticky event bits
    logic [IRQ_W-1:0] irq_en;      // interrupt enables
    logic [DATA_W-1:0] rdata;      // read data held for the access phase
    logic sync_out;                // sync output level
    logic boundary;                // cycle boundary flag
  } tb_state_s;

  tb_state_s s;
  tb_state_s n;

  // decoded control fields
  logic module_on;
  logic idle_halt;
  logic se_irq_en;
  logic imm_load;
  logic sync_pol;
  logic sync_oe;
  logic ext_sync_en;
  logic [SRC_W-1:0] src_sel;
  logic [PS_W-1:0] postscale;

  // time base events
  logic run;          // counter advances this cycle
  logic wrap;         // counter reached active period
  logic ext_restart;  // external sync restarts the count
  logic sevt_hit;     // special event compare match
  logic sync_pulse;   // asserting edge of the selected sync input
  logic se_event;     // postscaled special event

  // bus decode
  logic setup_rd;   // read in its setup cycle
  logic access_wr;  // write in its access cycle
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] irq_gate;

  // true when the address hits the given register
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  // true when the address hits any mapped register
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = addr_hit(a, OFF_CONTROL) | addr_hit(a, OFF_PERIOD) | addr_hit(a, OFF_COUNT)
      | addr_hit(a, OFF_SEVT_CMP) | addr_hit(a, OFF_IRQ_STATUS) | addr_hit(a, OFF_IRQ_ENABLE)
      | addr_hit(a, OFF_IRQ_CLEAR);
  endfunction : addr_mapped

  // widen a counter-width value to the bus
  function automatic logic [DATA_W-1:0] widen(input logic [CNT_W-1:0] v);
    widen = DATA_W'(v);
  endfunction : widen

  // control fields taken straight from the register
  assign module_on = s.control[BIT_MODULE_ON];
  assign idle_halt = s.control[BIT_IDLE_HALT];
  assign se_irq_en = s.control[BIT_SE_IRQ_EN];
  assign imm_load = s.control[BIT_IMM_LOAD];
  assign sync_pol = s.control[BIT_SYNC_POL];
  assign sync_oe = s.control[BIT_SYNC_OE];
  assign ext_sync_en = s.control[BIT_EXT_SYNC];
  assign src_sel = s.control[SRC_LSB +: SRC_W];
  assign postscale = s.control[PS_LSB +: PS_W];

  // bus phases; the slave never waits
  assign setup_rd = psel & ~penable & ~pwrite;
  assign access_wr = psel & penable & pwrite;

  // the sync edge detector and the postscaler live in their own modules;
  // the postscaler is cleared while the module is off so every run starts
  // counting events from zero

  // selected sync input with polarity applied
  sync_source_edge #(
    .SRC_N(SRC_N)
  ) u_sync_edge (
    .pclk(pclk),
    .presetn(presetn),
    .sync_sources(sync_sources),
    .select(src_sel),
    .invert(sync_pol),
    .sync_pulse(sync_pulse)
  );

  // special events divided down before they raise the pending bit
  event_postscaler u_postscaler (
    .pclk(pclk),
    .presetn(presetn),
    .clear(~module_on),
    .event_in(sevt_hit),
    .ratio(postscale),
    .event_out(se_event)
  );

  // counter timing: with the module on and not halted the count steps once a
  // clock and returns to zero the clock after it equals the active period, so
  // one cycle lasts period plus one clocks
  // a selected sync edge is flagged one clock after the pin asserts and clears
  // the count on the next edge; software should keep the period a little longer
  // than the sync spacing so the sync, not the wrap, starts each cycle
  // halting in idle freezes the count (an honoured sync edge still clears it) and also holds back special events,
  // since a frozen count would otherwise match its compare every clock

  // time base qualifiers
  always_comb begin
    // counting needs the module on and, with idle-halt set, a busy cpu
    run = module_on & ~(idle_halt & cpu_idle);
    wrap = run & (s.count == s.active);
    // a sync edge is only honoured while external sync is enabled
    ext_restart = module_on & ext_sync_en & sync_pulse;
    sevt_hit = run & (s.count == s.sevt_cmp);
  end

  // status bits:
  //   boundary - every wrap or external restart
  //   special  - every postscaled compare match, mirrored as the pending bit
  //   sync     - every honoured external sync edge
  // a clear write that meets a new event in the same clock loses, so no
  // event is dropped by a late clear
  // the pending bit reads back set until software clears the status bit

  // interrupt sources and software clears
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_BOUNDARY] = wrap | ext_restart;
    irq_set[IRQ_SPECIAL] = se_event;
    irq_set[IRQ_SYNC] = ext_restart;
    irq_clr = '0;
    if (access_wr && addr_hit(paddr, OFF_IRQ_CLEAR)) begin
      irq_clr = pwdata[IRQ_W-1:0];
    end
    // special event gated by its own enable in the control register
    irq_gate = s.irq_en;
    irq_gate[IRQ_SPECIAL] = s.irq_en[IRQ_SPECIAL] & se_irq_en;
  end

  // write side: writes land at the access edge with penable high; the
  // count and status registers have no write path, so writes to them are
  // simply dropped without an error
  // mode bits (immediate load, polarity, sync enables, source, postscale)
  // are safest changed with the module off; changing them while running
  // takes effect on the next clock with no attempt to smooth the switch
  // the enable, idle-halt and interrupt-enable bits may change at any time

  // next state of the whole block
  always_comb begin
    n = s;

    // register writes
    if (access_wr) begin
      if (addr_hit(paddr, OFF_CONTROL)) begin
        // pending and unimplemented bits keep their hardware value
        n.control = pwdata[CTRL_W-1:0] & CONTROL_WMASK;
      end
      if (addr_hit(paddr, OFF_PERIOD)) begin
        n.period = pwdata[CNT_W-1:0];
      end
      if (addr_hit(paddr, OFF_SEVT_CMP)) begin
        n.sevt_cmp = pwdata[CNT_W-1:0];
      end
      if (addr_hit(paddr, OFF_IRQ_ENABLE)) begin
        n.irq_en = pwdata[IRQ_W-1:0];
      end
    end

    // time base counter
    if (!module_on) begin
      // disabled module holds the count at zero
      n.count = '0;
    end else if (ext_restart) begin
      n.count = '0;
    end else if (wrap) begin
      n.count = '0;
    end else if (run) begin
      n.count = s.count + 1'b1;
    end else begin
      n.count = s.count;
    end
    n.boundary = wrap | ext_restart;

    // with immediate load the new period reaches the compare at the write
    // edge itself, so a period shorter than the current count lets the
    // count run on past it until the sixteen-bit wrap; buffered load avoids
    // that by waiting for the end of the cycle

    // active period load
    if (imm_load) begin
      // follows the written value in the same cycle it lands
      n.active = n.period;
    end else if (wrap || ext_restart || !module_on) begin
      // buffered until the cycle ends; a disabled module loads freely
      n.active = s.period;
    end else begin
      n.active = s.active;
    end

    // sticky status: a set in the clearing cycle wins
    n.irq_status = (s.irq_status & ~irq_clr) | irq_set;

    // the sync output idles at the inactive level of the chosen polarity and
    // shows one active clock per boundary; a disabled output sits low so the
    // pad sees a quiet line whatever the polarity

    // sync output marks each boundary at the chosen polarity
    if (sync_oe) begin
      n.sync_out = (wrap | ext_restart) ^ sync_pol;
    end else begin
      n.sync_out = 1'b0;
    end

    // read data is taken in the setup cycle and held in a register, so the
    // access phase needs no wait state and prdata stays put until the next
    // read setup; write setups leave it untouched

    // read data captured in the setup cycle
    if (setup_rd) begin
      n.rdata = '0;
      case (paddr)
        OFF_CONTROL: begin
          // pending bit reflects the hardware status
          n.rdata[CTRL_W-1:0] = s.control;
          n.rdata[BIT_SE_PENDING] = s.irq_status[IRQ_SPECIAL];
          n.rdata[BIT_UNUSED] = 1'b0;
        end
        OFF_PERIOD: begin
          n.rdata = widen(s.period);
        end
        OFF_COUNT: begin
          n.rdata = widen(s.count);
        end
        OFF_SEVT_CMP: begin
          n.rdata = widen(s.sevt_cmp);
        end
        OFF_IRQ_STATUS: begin
          n.rdata[IRQ_W-1:0] = s.irq_status;
        end
        OFF_IRQ_ENABLE: begin
          n.rdata[IRQ_W-1:0] = s.irq_en;
        end
        default: begin
          // clear register and holes read as zero
          n.rdata = '0;
        end
      endcase
    end
  end

  // reset values: everything zero, so the module comes up off, with the
  // sync output disabled and no interrupt; the count and active period
  // start at zero as well

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.control <= CONTROL_RST;
      s.period <= CNT_W'(PERIOD_RST);
      s.active <= CNT_W'(PERIOD_RST);
      s.count <= '0;
      s.sevt_cmp <= CNT_W'(SEVT_CMP_RST);
      s.irq_status <= IRQ_RST;
      s.irq_en <= IRQ_RST;
      s.rdata <= '0;
      s.sync_out <= 1'b0;
      s.boundary <= 1'b0;
    end else begin
      s <= n;
    end
  end

  // the slave is zero wait: pready is always high and every transfer ends in
  // its first access cycle; pslverr marks unmapped addresses only in the
  // access cycle, as the bus expects

  // bus answers: zero wait, error on unmapped addresses
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_mapped(paddr);
  assign prdata = s.rdata;

  // sync_output_en follows the enable bit directly so the pad driver changes
  // with the register, while the pin level follows one clock later

  // pins and status outputs
  assign sync_output_pin = s.sync_out;
  assign sync_output_en = sync_oe;
  assign pwm_running = module_on;
  assign period_boundary = s.boundary;
  assign count_value = s.count;
  assign active_period = s.active;

  // the special-event bit needs both its enable register bit and the
  // interrupt enable bit in the control register; the other sources use
  // their enable register bit alone

  // one level interrupt from enabled sticky bits
  assign irq = |(s.irq_status & irq_gate);

endmodule : pwm_timebase_control

// >>> dv/pwm_timebase_monitor.sv
// port checks for the pwm time base control block
`timescale 1ns/10ps
module pwm_timebase_monitor
  import pwm_timebase_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_idle,
  input wire logic sync_output_pin,
  input wire logic sync_output_en,
  input wire logic pwm_running,
  input wire logic period_boundary,
  input wire logic [CNT_W-1:0] count_value,
  input wire logic [CNT_W-1:0] active_period
);
  // every check samples on the bus clock and rests in reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a running, non-halted count sits on its period
  logic at_top;
  assign at_top = pwm_running && !cpu_idle && count_value == active_period;

  a_off_count_zero: assert property (!pwm_running ##1 !pwm_running |-> count_value == '0)
    else $error("count not zero while off");
  a_count_wrap: assert property (at_top |=> count_value == '0)
    else $error("count missed its wrap");
  a_count_step: assert property (pwm_running && !cpu_idle && count_value < active_period
    |=> count_value == $past(count_value) + 1'b1 || count_value == '0)
    else $error("count did not step by one");
  a_wrap_boundary: assert property (at_top ##1 pwm_running |-> ##[0:1] period_boundary)
    else $error("no boundary pulse after wrap");
  a_oe_pin_low: assert property (!sync_output_en ##1 !sync_output_en |-> !sync_output_pin)
    else $error("sync pin active while disabled");
  a_ready_high: assert property (pready)
    else $error("ready dropped");
  a_err_decode: assert property (pslverr == (psel && penable && (paddr > 8'h18 || paddr[1:0] != 2'h0)))
    else $error("error response mismatch");
  a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside read setup");
endmodule : pwm_timebase_monitor

bind pwm_timebase_control pwm_timebase_monitor #(.CNT_W(CNT_W)) mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cpu_idle(cpu_idle), .sync_output_pin(sync_output_pin),
  .sync_output_en(sync_output_en), .pwm_running(pwm_running), .period_boundary(period_boundary),
  .count_value(count_value), .active_period(active_period));

// >>> dv/sync_partner.sv
// external sync source model feeding the block's sync inputs
`timescale 1ns/10ps
module sync_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  input wire logic pol,
  input wire logic [2:0] src,
  output logic [7:0] sync_sources
);
  // lines rest inactive; fire asserts the chosen line for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_sources <= 8'h00;
    end else begin
      sync_sources <= {8{pol}} ^ (fire ? 8'h01 << src : 8'h00);
    end
  end
endmodule : sync_partner

// >>> dv/pwm_timebase_control_bench.sv
// self-checking bench for the pwm time base control block
`timescale 1ns/10ps
module pwm_timebase_control_bench
  import pwm_timebase_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, cpu_idle, fire, pol, err;
  logic pready, pslverr, sync_output_pin, sync_output_en, pwm_running, period_boundary, irq;
  logic [7:0] paddr, sync_sources;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] count_value, active_period, v;
  logic [2:0] src;
  int miscompares = 0;
  int checked = 0;

  pwm_timebase_control uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_idle(cpu_idle), .sync_sources(sync_sources),
    .sync_output_pin(sync_output_pin), .sync_output_en(sync_output_en), .pwm_running(pwm_running),
    .period_boundary(period_boundary), .count_value(count_value), .active_period(active_period),
    .irq(irq));
  sync_partner sp (.pclk(pclk), .presetn(presetn), .fire(fire), .pol(pol), .src(src),
    .sync_sources(sync_sources));

  // one apb transfer; data and error taken at the ready edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // word compare
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  // single bit compare
  task automatic cmpb(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t bit %b exp %b", $time, got, exp);
    end
  endtask : cmpb

  // register read against an expected word
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask : rdchk

  // bounded wait for a boundary pulse
  task automatic wait_bnd();
    int i;
    for (i = 0; i < 300 && period_boundary !== 1'b1; i++) @(posedge pclk);
    cmpb(period_boundary, 1'b1);
  endtask : wait_bnd

  // verdict and end of run
  task automatic finish_test();
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // bus clock, 40 ns period
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // tests need well under a thousand cycles; this allows 25000
  initial begin
    #1000000;
    miscompares++;
    finish_test();
  end

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cpu_idle = 1'b0;
    fire = 1'b0;
    pol = 1'b0;
    src = 3'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFF_CONTROL, 32'h0);
    rdchk(OFF_COUNT, 32'h0);
    rdchk(OFF_IRQ_STATUS, 32'h0);
    // reserved and status bits ignore writes
    xfer(1'b1, OFF_CONTROL, 32'h5000);
    rdchk(OFF_CONTROL, 32'h0);
    // boundary-timed period load
    xfer(1'b1, OFF_PERIOD, 32'h5);
    xfer(1'b1, OFF_CONTROL, 32'h8000);
    @(negedge pclk);
    cmpb(pwm_running, 1'b1);
    cmp(32'(active_period), 32'h5);
    wait_bnd();
    xfer(1'b1, OFF_PERIOD, 32'h9);
    @(negedge pclk);
    cmp(32'(active_period), 32'h5);
    wait_bnd();
    @(negedge pclk);
    cmp(32'(active_period), 32'h9);
    // immediate load, mode changed only while off
    xfer(1'b1, OFF_CONTROL, 32'h0);
    xfer(1'b1, OFF_CONTROL, 32'h8400);
    xfer(1'b1, OFF_PERIOD, 32'h7);
    @(negedge pclk);
    cmp(32'(active_period), 32'h7);
    // halt in idle, then run in idle
    xfer(1'b1, OFF_CONTROL, 32'ha400);
    cpu_idle <= 1'b1;
    repeat (2) @(posedge pclk);
    v = count_value;
    repeat (4) @(posedge pclk);
    cmp(32'(count_value), 32'(v));
    xfer(1'b1, OFF_CONTROL, 32'h8400);
    repeat (2) @(posedge pclk);
    v = count_value;
    @(posedge pclk);
    cmpb(count_value == v, 1'b0);
    cpu_idle <= 1'b0;
    // special event every second match, interrupt masked then enabled
    xfer(1'b1, OFF_CONTROL, 32'h0);
    xfer(1'b1, OFF_IRQ_CLEAR, 32'h7);
    xfer(1'b1, OFF_SEVT_CMP, 32'h3);
    xfer(1'b1, OFF_IRQ_ENABLE, 32'h2);
    xfer(1'b1, OFF_CONTROL, 32'h8401);
    // first match is held back by the postscaler, only the wrap shows
    repeat (8) @(posedge pclk);
    rdchk(OFF_IRQ_STATUS, 32'h1);
    repeat (30) @(posedge pclk);
    rdchk(OFF_IRQ_STATUS, 32'h3);
    rdchk(OFF_CONTROL, 32'h9401);
    cmpb(irq, 1'b0);
    xfer(1'b1, OFF_CONTROL, 32'h8c01);
    @(negedge pclk);
    cmpb(irq, 1'b1);
    xfer(1'b1, OFF_CONTROL, 32'h0);
    xfer(1'b1, OFF_IRQ_CLEAR, 32'h7);
    rdchk(OFF_IRQ_STATUS, 32'h0);
    rdchk(OFF_IRQ_CLEAR, 32'h0);
    cmpb(irq, 1'b0);
    // unmapped address
    xfer(1'b0, 8'h40, 32'h0);
    cmpb(err, 1'b1);
    cmp(rd, 32'h0);
    // inverted sync, source three, period above the sync spacing
    pol <= 1'b1;
    src <= 3'h3;
    xfer(1'b1, OFF_PERIOD, 32'hc8);
    xfer(1'b1, OFF_CONTROL, 32'h83b0);
    repeat (20) @(posedge pclk);
    cmpb(sync_output_en, 1'b1);
    cmpb(sync_output_pin, 1'b1);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    cmp(32'(count_value), 32'h0);
    cmpb(sync_output_pin, 1'b0);
    // a pulse on an unselected line is ignored
    src <= 3'h2;
    repeat (20) @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    cmpb(count_value > 16'h2, 1'b1);
    xfer(1'b1, OFF_CONTROL, 32'h0);
    @(negedge pclk);
    cmpb(sync_output_en, 1'b0);
    finish_test();
  end
endmodule : pwm_timebase_control_bench
